// ===== design/sat_translator.sv
`default_nettype none
module sat_translator (
  input wire logic clk,
  input wire logic rst,
  input wire logic ce,
  input wire logic req_valid,
  input wire sat_pkg::sat_req_t req,
  output logic req_ready,
  input wire logic absolute_mode,
  input wire logic privileged,
  input wire logic tbl_load,
  input wire logic [sat_pkg::ABS_W-1:0] tbl_org_in,
  input wire logic [sat_pkg::SIZE_W-1:0] tbl_size_in,
  input wire logic base_load,
  input wire logic [sat_pkg::BASE_NUM_W-1:0] base_sel_in,
  input wire logic [sat_pkg::SEG_W-1:0] base_seg_in,
  input wire logic code_load,
  input wire logic [sat_pkg::SEG_W-1:0] code_seg_in,
  input wire logic operand_load,
  input wire logic [sat_pkg::SEG_W-1:0] operand_seg_in,
  output logic mem_rd,
  output logic [sat_pkg::ABS_W-1:0] mem_addr,
  input wire logic mem_ack,
  input wire logic [sat_pkg::WORD_W-1:0] mem_data,
  output logic rsp_valid,
  output sat_pkg::sat_rsp_t rsp
);
  // Sequencer states
  typedef enum logic [2:0] {S_IDLE, S_BASE, S_DESC, S_WAIT, S_DONE} sat_state_t;

  // ----------------------------------------------------------------
  // Helper functions
  // ----------------------------------------------------------------
  function automatic logic [sat_pkg::ABS_W-1:0] sat_add(input logic [sat_pkg::ABS_W-1:0] base,
                                                        input logic [sat_pkg::SEG_W-1:0] offs);
    sat_add = base + {{(sat_pkg::ABS_W - sat_pkg::SEG_W){1'b0}}, offs};
  endfunction : sat_add

  function automatic logic sat_inside(input logic [sat_pkg::SEG_W-1:0] offs,
                                      input logic [sat_pkg::SIZE_W-1:0] size);
    sat_inside = {1'b0, offs} < size;
  endfunction : sat_inside

  // ----------------------------------------------------------------
  // State
  // ----------------------------------------------------------------
  sat_state_t state_r, state_nxt;
  logic [sat_pkg::ABS_W-1:0] tbl_org_r;
  logic [sat_pkg::SIZE_W-1:0] tbl_size_r;
  logic [sat_pkg::SEG_W-1:0] code_seg_r;
  logic [sat_pkg::SEG_W-1:0] operand_seg_r;
  logic [sat_pkg::SEG_W-1:0] seg_r;
  logic [sat_pkg::SEG_W-1:0] offs_r;
  logic use_base_r;
  logic [sat_pkg::BASE_NUM_W-1:0] base_sel_r;
  logic [sat_pkg::SEG_W-1:0] base_seg;

  // ----------------------------------------------------------------
  // Request decode
  // ----------------------------------------------------------------
  wire logic in_base_form = ~req.fetch & req.instr[sat_pkg::BASE_FORM_BIT];
  wire logic [sat_pkg::BASE_NUM_W-1:0] base_pick =
    req.instr[sat_pkg::SEL_HI:sat_pkg::SEL_LO];
  wire logic [sat_pkg::SEG_W-1:0] field_offs = req.instr[sat_pkg::SEG_W-1:0];
  wire logic [sat_pkg::SEG_W-1:0] base_offs =
    {3'h0, field_offs[sat_pkg::OFFS_HI:sat_pkg::OFFS_LO]};
  wire logic [sat_pkg::SEG_W-1:0] req_offs = req.fetch ? req.counter
                                           : (in_base_form ? base_offs : field_offs);
  wire logic [sat_pkg::SEG_W-1:0] req_seg = req.fetch ? code_seg_r : operand_seg_r;
  wire logic take = req_valid & req_ready; // Ready is low in the first cycle after reset
  wire logic go_abs = req.fetch & absolute_mode;

  // ----------------------------------------------------------------
  // Descriptor decode
  // ----------------------------------------------------------------
  wire logic [sat_pkg::SEG_W-1:0] cur_seg = use_base_r ? base_seg : seg_r;
  wire logic seg_in_tbl = sat_inside(cur_seg, tbl_size_r);
  wire logic [sat_pkg::ABS_W-1:0] desc_addr = sat_add(tbl_org_r, cur_seg);

  // Fields of the descriptor word
  wire logic [sat_pkg::ABS_W-1:0] seg_org =
    {mem_data[sat_pkg::DESC_ORG_LO +: sat_pkg::SEG_W], 6'h00};
  wire logic [sat_pkg::SIZE_W-1:0] seg_size =
    {1'b0, mem_data[sat_pkg::DESC_SIZE_LO +: sat_pkg::DESC_SIZE_W], 6'h00};
  wire logic [sat_pkg::DESC_CTL_W-1:0] seg_ctl =
    mem_data[sat_pkg::DESC_CTL_LO +: sat_pkg::DESC_CTL_W];
  wire logic offs_ok = sat_inside(offs_r, seg_size);
  wire logic [sat_pkg::ABS_W-1:0] abs_addr = sat_add(seg_org, offs_r);

  // ----------------------------------------------------------------
  // Segment select bases
  // ----------------------------------------------------------------
  // Base number held from the take edge, so the pipeline may move on
  sat_base_file u_bases (
    .clk(clk),
    .rst(rst),
    .ce(ce),
    .wr_en(base_load),
    .wr_sel(base_sel_in),
    .wr_seg(base_seg_in),
    .rd_sel(base_sel_r),
    .rd_seg(base_seg)
  );

  // ----------------------------------------------------------------
  // Sequencer
  // ----------------------------------------------------------------
  always_comb begin
    state_nxt = state_r;
    unique case (state_r)
      S_IDLE: begin
        if (take) state_nxt = go_abs ? S_DONE : (in_base_form ? S_BASE : S_DESC);
      end
      S_BASE: state_nxt = S_DESC;
      S_DESC: state_nxt = seg_in_tbl ? S_WAIT : S_DONE;
      S_WAIT: begin
        if (mem_ack) state_nxt = S_DONE;
      end
      S_DONE: state_nxt = S_IDLE;
      default: state_nxt = S_IDLE;
    endcase
  end

  // ----------------------------------------------------------------
  // Registers
  // ----------------------------------------------------------------
  // State and table base
  always_ff @(posedge clk) begin
    if (rst) begin
      state_r <= S_IDLE;
      tbl_org_r <= sat_pkg::RST_TBL_ORG;
      tbl_size_r <= sat_pkg::RST_TBL_SIZE;
    end else if (ce) begin
      state_r <= state_nxt;
      if (tbl_load && privileged) begin
        tbl_org_r <= tbl_org_in;
        tbl_size_r <= tbl_size_in;
      end
    end
  end

  // Current segment bases
  always_ff @(posedge clk) begin
    if (rst) begin
      code_seg_r <= sat_pkg::RST_SEG;
      operand_seg_r <= sat_pkg::RST_SEG;
    end else if (ce) begin
      if (code_load) code_seg_r <= code_seg_in;
      if (operand_load) operand_seg_r <= operand_seg_in;
    end
  end

  // Captured request
  always_ff @(posedge clk) begin
    if (rst) begin
      seg_r <= sat_pkg::RST_SEG;
      offs_r <= sat_pkg::RST_SEG;
      use_base_r <= 1'b0;
      base_sel_r <= '0;
    end else if (ce && take) begin
      seg_r <= req_seg;
      offs_r <= req_offs;
      use_base_r <= in_base_form;
      base_sel_r <= base_pick;
    end
  end

  // ----------------------------------------------------------------
  // Outputs
  // ----------------------------------------------------------------
  // Memory read of descriptor entry
  always_ff @(posedge clk) begin
    if (rst) begin
      mem_rd <= 1'b0;
      mem_addr <= sat_pkg::RST_TBL_ORG;
    end else if (ce) begin
      mem_rd <= (state_nxt == S_WAIT);
      if (state_r == S_DESC) mem_addr <= desc_addr;
    end
  end

  // Answer to the pipeline
  always_ff @(posedge clk) begin
    if (rst) begin
      rsp_valid <= 1'b0;
      rsp <= '0;
      req_ready <= 1'b0;
    end else if (ce) begin
      rsp_valid <= 1'b0;
      req_ready <= (state_nxt == S_IDLE);
      if (take && go_abs) begin
        rsp_valid <= 1'b1;
        rsp <= '{fault: 1'b0, addr: {6'h00, req.counter}, ctl: '0};
      end else if (state_r == S_DESC && !seg_in_tbl) begin
        rsp_valid <= 1'b1;
        rsp <= '{fault: 1'b1, addr: '0, ctl: '0};
      end else if (state_r == S_WAIT && mem_ack) begin
        rsp_valid <= 1'b1;
        rsp <= '{fault: ~offs_ok, addr: offs_ok ? abs_addr : '0, ctl: seg_ctl};
      end
    end
  end
endmodule : sat_translator
`default_nettype wire

// ===== design/sat_pkg.sv
`default_nettype none
package sat_pkg;
  // ----------------------------------------------------------------
  // Widths
  // ----------------------------------------------------------------
  localparam int unsigned ADDR_W = 18;
  localparam int unsigned SEG_W = 18;
  localparam int unsigned ABS_W = 24;
  localparam int unsigned SIZE_W = 19;
  localparam int unsigned BASE_NUM_W = 3;
  localparam int unsigned BASE_CNT = 8;
  localparam int unsigned WORD_W = 36;
  // ----------------------------------------------------------------
  // Instruction fields
  // ----------------------------------------------------------------
  localparam int unsigned BASE_FORM_BIT = 29;
  localparam int unsigned SEL_HI = 17;
  localparam int unsigned SEL_LO = 15;
  localparam int unsigned OFFS_HI = 14;
  localparam int unsigned OFFS_LO = 0;
  // ----------------------------------------------------------------
  // Descriptor entry layout: origin, size, control
  // ----------------------------------------------------------------
  localparam int unsigned DESC_ORG_LO = 0;
  localparam int unsigned DESC_SIZE_LO = 18;
  localparam int unsigned DESC_SIZE_W = 12;
  localparam int unsigned DESC_CTL_LO = 30;
  localparam int unsigned DESC_CTL_W = 6;
  localparam int unsigned DESC_SIZE_SHIFT = 6;
  localparam int unsigned DESC_ORG_SHIFT = 6;
  // ----------------------------------------------------------------
  // Reset values
  // ----------------------------------------------------------------
  localparam logic [ABS_W-1:0] RST_TBL_ORG = 24'h000000;
  localparam logic [SIZE_W-1:0] RST_TBL_SIZE = 19'h00000;
  localparam logic [SEG_W-1:0] RST_SEG = 18'h00000;

  // Request from the execution pipeline
  typedef struct packed {
    logic fetch;
    logic [WORD_W-1:0] instr;
    logic [ADDR_W-1:0] counter;
  } sat_req_t;

  // Answer to the execution pipeline
  typedef struct packed {
    logic fault;
    logic [ABS_W-1:0] addr;
    logic [DESC_CTL_W-1:0] ctl;
  } sat_rsp_t;
endpackage : sat_pkg
`default_nettype wire

// ===== design/sat_base_file.sv
`default_nettype none
// ----------------------------------------------------------------
// Eight segment select bases, registered read
// ----------------------------------------------------------------
module sat_base_file (
  input wire logic clk,
  input wire logic rst,
  input wire logic ce,
  input wire logic wr_en,
  input wire logic [sat_pkg::BASE_NUM_W-1:0] wr_sel,
  input wire logic [sat_pkg::SEG_W-1:0] wr_seg,
  input wire logic [sat_pkg::BASE_NUM_W-1:0] rd_sel,
  output logic [sat_pkg::SEG_W-1:0] rd_seg
);
  logic [sat_pkg::SEG_W-1:0] mem_r [sat_pkg::BASE_CNT];

  // Storage and registered read
  always_ff @(posedge clk) begin
    if (rst) begin
      for (int i = 0; i < sat_pkg::BASE_CNT; i++) mem_r[i] <= sat_pkg::RST_SEG;
      rd_seg <= sat_pkg::RST_SEG;
    end else if (ce) begin
      if (wr_en) mem_r[wr_sel] <= wr_seg;
      rd_seg <= mem_r[rd_sel];
    end
  end
endmodule : sat_base_file
`default_nettype wire

// ===== bench/sat_translator_sva.sv
`default_nettype none
module sat_chk (
  input wire logic clk,
  input wire logic rst,
  input wire logic ce,
  input wire logic req_valid,
  input wire sat_pkg::sat_req_t req,
  input wire logic req_ready,
  input wire logic absolute_mode,
  input wire logic mem_rd,
  input wire logic [23:0] mem_addr,
  input wire logic mem_ack,
  input wire logic [35:0] mem_data,
  input wire logic rsp_valid,
  input wire sat_pkg::sat_rsp_t rsp
);
  timeunit 1ns;
  timeprecision 1ns;
  default clocking @(posedge clk); endclocking
  default disable iff (rst);
  // Request taken, its kind and the size limit
  wire logic tk = ce && req_valid && req_ready;
  wire logic op = tk && !req.fetch;
  wire logic dn = mem_rd && mem_ack;
  wire logic [17:0] lim = {mem_data[29:18], 6'h0};
  logic [17:0] off_r;
  // Offset of the request in flight
  always_ff @(posedge clk) begin
    if (tk) begin
      off_r <= req.fetch ? req.counter : req.instr[29] ? {3'h0, req.instr[14:0]} : req.instr[17:0];
    end
  end
  property p_abs;
    tk && req.fetch && absolute_mode |=> rsp_valid && !mem_rd && !rsp.fault && rsp.addr == {6'h0, $past(req.counter)};
  endproperty
  a_abs: assert property (p_abs) else $error("absolute fetch");
  property p_op2;
    op && !req.instr[29] |-> ##2 (mem_rd != rsp_valid);
  endproperty
  a_op2: assert property (p_op2) else $error("operand latency");
  property p_op3;
    op && req.instr[29] |-> ##2 !mem_rd ##1 (mem_rd != rsp_valid);
  endproperty
  a_op3: assert property (p_op3) else $error("base form latency");
  property p_hold;
    mem_rd && !mem_ack |=> mem_rd && $stable(mem_addr);
  endproperty
  a_hold: assert property (p_hold) else $error("table read dropped");
  property p_ack;
    dn |=> rsp_valid && !mem_rd;
  endproperty
  a_ack: assert property (p_ack) else $error("no answer");
  property p_sum;
    dn && off_r < lim |=> !rsp.fault && rsp.ctl == $past(mem_data[35:30])
      && rsp.addr == {$past(mem_data[17:0]), 6'h0} + 24'(off_r);
  endproperty
  a_sum: assert property (p_sum) else $error("bad sum");
  property p_bnd;
    dn && off_r >= lim |=> rsp_valid && rsp.fault;
  endproperty
  a_bnd: assert property (p_bnd) else $error("no bound fault");
  property p_chg;
    $changed(rsp) |-> rsp_valid;
  endproperty
  a_chg: assert property (p_chg) else $error("answer moved");
endmodule : sat_chk
bind sat_translator sat_chk u_chk (.clk(clk), .rst(rst), .ce(ce), .req_valid(req_valid), .req(req),
  .req_ready(req_ready), .absolute_mode(absolute_mode), .mem_rd(mem_rd), .mem_addr(mem_addr),
  .mem_ack(mem_ack), .mem_data(mem_data), .rsp_valid(rsp_valid), .rsp(rsp));
`default_nettype wire

// ===== bench/sat_mem.sv
`default_nettype none
module sat_mem (
  input wire logic clk,
  input wire logic mem_rd,
  input wire logic [23:0] mem_addr,
  output logic mem_ack,
  output logic [35:0] mem_data
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [35:0] tbl [64];
  int wait_cyc = 0;
  int cnt = 0;
  initial begin
    mem_ack = 1'b0;
    mem_data = 36'h0;
  end
  // Answer a table read after a set wait
  always @(posedge clk) begin
    if (mem_rd && !mem_ack && cnt >= wait_cyc) begin
      mem_ack <= 1'b1;
      mem_data <= tbl[mem_addr[5:0]];
      cnt <= 0;
    end else begin
      mem_ack <= 1'b0;
      mem_data <= ~mem_data; // No stale word
      cnt <= mem_rd ? cnt + 1 : 0;
    end
  end
endmodule : sat_mem
`default_nettype wire

// ===== bench/sat_translator_bench.sv
`default_nettype none
module sat_translator_bench;
  timeunit 1ns;
  timeprecision 1ns;
  logic clk, rst, req_valid, req_ready, absolute_mode, privileged, tbl_load, base_load;
  logic code_load, operand_load, mem_rd, mem_ack, rsp_valid, ce;
  logic [23:0] tbl_org_in, mem_addr, ma_seen;
  logic [18:0] tbl_size_in;
  logic [2:0] base_sel_in;
  logic [17:0] base_seg_in, code_seg_in, operand_seg_in;
  logic [35:0] mem_data;
  sat_pkg::sat_req_t req;
  sat_pkg::sat_rsp_t rsp;
  int err_total = 0;
  int num_checks = 0;
  sat_translator dut (.clk(clk), .rst(rst), .ce(ce), .req_valid(req_valid), .req(req), .req_ready(req_ready),
    .absolute_mode(absolute_mode), .privileged(privileged), .tbl_load(tbl_load), .tbl_org_in(tbl_org_in),
    .tbl_size_in(tbl_size_in), .base_load(base_load), .base_sel_in(base_sel_in), .base_seg_in(base_seg_in),
    .code_load(code_load), .code_seg_in(code_seg_in), .operand_load(operand_load),
    .operand_seg_in(operand_seg_in), .mem_rd(mem_rd), .mem_addr(mem_addr), .mem_ack(mem_ack),
    .mem_data(mem_data), .rsp_valid(rsp_valid), .rsp(rsp));
  sat_mem mem (.clk(clk), .mem_rd(mem_rd), .mem_addr(mem_addr), .mem_ack(mem_ack), .mem_data(mem_data));
  // Clock and hang guard
  initial begin
    clk = 1'b0;
    forever #25 clk = ~clk;
  end
  initial begin
    #200000;
    err_total++;
    stop_test;
  end
  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    num_checks++;
    if (got !== exp) begin
      err_total++;
      $display("CHECK FAILED %0t got %h exp %h", $time, got, exp);
    end
  endtask : check
  task automatic stop_test;
    $display("checks %0d errors %0d", num_checks, err_total);
    if (err_total == 0 && num_checks > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask : stop_test
  function automatic logic [23:0] sa(input int s, input int o);
    return 24'(s * 256 + o);
  endfunction : sa
  // One request, answer judged
  task automatic xfer(input logic f, input logic [35:0] ins, input logic [17:0] ctr, input logic ef,
                      input logic [23:0] ea, input logic [23:0] ema);
    int n;
    n = 0;
    ma_seen = '1;
    @(negedge clk);
    req_valid = 1'b1;
    req = '{f, ins, ctr};
    do @(posedge clk); while (req_ready !== 1'b1);
    @(negedge clk);
    req_valid = 1'b0;
    while (rsp_valid !== 1'b1 && n < 40) begin
      if (mem_rd) begin
        ma_seen = mem_addr;
      end
      @(negedge clk);
      n++;
    end
    check(32'(rsp_valid), 32'h1);
    check(32'(rsp.fault), 32'(ef));
    if (!ef) begin
      check(32'(rsp.addr), 32'(ea));
    end
    check(32'(ma_seen), 32'(ema));
  endtask : xfer
  task automatic ld_tbl(input logic p, input logic [23:0] org);
    @(negedge clk);
    privileged = p;
    tbl_org_in = org;
    tbl_load = 1'b1;
    @(negedge clk);
    tbl_load = 1'b0;
  endtask : ld_tbl
  task automatic ld_op(input logic [17:0] s);
    @(negedge clk);
    operand_seg_in = s;
    operand_load = 1'b1;
    @(negedge clk);
    operand_load = 1'b0;
  endtask : ld_op
  // Fetches: absolute, then by code base
  task automatic t_fetch;
    absolute_mode = 1'b1;
    xfer(1'b1, 36'h0, 18'h2abcd, 1'b0, 24'h02abcd, '1);
    absolute_mode = 1'b0;
    xfer(1'b1, 36'h0, 18'h0005f, 1'b0, sa(1, 'h5f), 24'h000101);
    $display("t_fetch done");
  endtask : t_fetch
  // Operand bounds with slow memory
  task automatic t_op;
    mem.wait_cyc = 3;
    xfer(1'b0, 36'h7f, 18'h0, 1'b0, sa(2, 'h7f), 24'h000102);
    xfer(1'b0, 36'h80, 18'h0, 1'b1, 24'h0, 24'h000102);
    xfer(1'b0, 36'h38000, 18'h0, 1'b1, 24'h0, 24'h000102);
    mem.wait_cyc = 0;
    $display("t_op done");
  endtask : t_op
  // Every select base in base form
  task automatic t_base;
    for (int k = 0; k < 8; k++) begin
      xfer(1'b0, 36'h020000000 | 36'(k * 32768 + 5), 18'h0, 1'b0, sa(k + 3, 5), 24'(259 + k));
    end
    $display("t_base done");
  endtask : t_base
  // Table base privilege and table size
  task automatic t_tbl;
    ld_tbl(1'b0, 24'h000200);
    xfer(1'b0, 36'h10, 18'h0, 1'b0, sa(2, 16), 24'h000102);
    ld_tbl(1'b1, 24'h000140);
    ld_op(18'hf);
    xfer(1'b0, 36'h10, 18'h0, 1'b0, sa(15, 16), 24'h00014f);
    ld_op(18'h10);
    xfer(1'b0, 36'h10, 18'h0, 1'b1, 24'h0, '1);
    $display("t_tbl done");
  endtask : t_tbl
  // Clock enable low freezes the operand segment
  task automatic t_ce;
    @(negedge clk);
    ce = 1'b0;
    ld_op(18'h5);
    ce = 1'b1;
    xfer(1'b0, 36'h10, 18'h0, 1'b0, sa(2, 16), 24'h000102);
    $display("t_ce done");
  endtask : t_ce
  // Largest segment the size field can give
  task automatic t_size;
    mem.tbl[14] = {6'h0e, 12'hfff, 18'h00040};
    ld_op(18'he);
    xfer(1'b0, 36'h3ffbf, 18'h0, 1'b0, 24'h040fbf, 24'h00010e);
    xfer(1'b0, 36'h3ffc0, 18'h0, 1'b1, 24'h0, 24'h00010e);
    ld_op(18'h2);
    $display("t_size done");
  endtask : t_size
  // Reset in mid-run zeroes the table size
  task automatic t_rst;
    @(negedge clk);
    rst = 1'b1;
    repeat (2) @(negedge clk);
    check(32'({req_ready, mem_rd, rsp_valid}), 32'h0);
    check(32'(rsp), 32'h0);
    rst = 1'b0;
    xfer(1'b0, 36'h10, 18'h0, 1'b1, 24'h0, '1);
    $display("t_rst done");
  endtask : t_rst
  // Reset, setup, tests
  initial begin
    rst = 1'b1;
    {req_valid, absolute_mode, privileged, tbl_load, base_load, code_load, operand_load} = '0;
    {tbl_org_in, base_sel_in, base_seg_in, operand_seg_in} = '0;
    tbl_size_in = 19'h10;
    ce = 1'b1;
    code_seg_in = 18'h1;
    req = '0;
    for (int s = 0; s < 64; s++) begin
      mem.tbl[s] = {6'(s), 12'h002, 18'(s * 4)};
    end
    repeat (3) @(posedge clk);
    @(negedge clk);
    rst = 1'b0;
    code_load = 1'b1;
    @(negedge clk);
    code_load = 1'b0;
    for (int k = 0; k < 8; k++) begin
      base_load = 1'b1;
      base_sel_in = 3'(k);
      base_seg_in = 18'(k + 3);
      @(negedge clk);
    end
    base_load = 1'b0;
    ld_tbl(1'b1, 24'h000100);
    ld_op(18'h2);
    t_fetch;
    t_op;
    t_ce;
    t_size;
    t_base;
    t_tbl;
    t_rst;
    stop_test;
  end
endmodule : sat_translator_bench
`default_nettype wire
